// File: pkg/flash_erase_defines.svh
// register map, field positions, reset values and timing counts of the erase sequencer
`ifndef FLASH_ERASE_DEFINES_SVH
`define FLASH_ERASE_DEFINES_SVH

`define FES_OFS_CTRL        8'h00
`define FES_OFS_CLKCFG      8'h04
`define FES_OFS_STATUS      8'h08

`define FES_CTRL_ERASE      0
`define FES_CTRL_MASS       1
`define FES_CTRL_GLOBAL     2
`define FES_CTRL_PROG       3
`define FES_CTRL_BLKPROG    4
`define FES_CTRL_ARRAY      5

`define FES_CLK_SRC_LSB     0
`define FES_CLK_DIV_LSB     8

`define FES_STAT_BUSY       0
`define FES_STAT_LOCK       1
`define FES_STAT_ACCV       2

`define FES_CTRL_RST        6'h00
`define FES_CLK_SRC_RST     2'h1
`define FES_CLK_DIV_RST     6'h00
`define FES_LOCK_RST        1'b1

`define FES_MAIN_SEG_BYTES  512
`define FES_INFO_SEG_SMALL  64
`define FES_INFO_SEG_LARGE  128
`define FES_INFO_BASE       16'h1000
`define FES_MAIN_BASE       16'hf000
`define FES_MAIN_SEGS       8
`define FES_ERASE_FTG_CYCLES 4819

`endif

// File: pkg/flash_erase_pkg.sv
// types shared by the flash erase sequencer
package flash_erase_pkg;
    typedef enum logic [1:0] {
        SRC_AUX,
        SRC_SUB_MAIN,
        SRC_MAIN,
        SRC_RSVD
    } clk_src_e;

    typedef enum logic [1:0] {
        MODE_NONE,
        MODE_SEGMENT,
        MODE_MASS,
        MODE_ALL
    } erase_mode_e;

    typedef enum {
        ST_READ,
        ST_ERASE
    } seq_state_e;

    typedef logic [15:0] flash_addr_t;
endpackage

// File: src/flash_erase_sequencer.sv
// erase sequencer of an on-chip flash array with wishbone control registers
//
// Local design decisions: the placing of the registers and the Wishbone slave port.
`timescale 1ns/100ps
`include "flash_erase_defines.svh"

module flash_erase_sequencer #(
    parameter int DUAL_ARRAY       = 0,
    parameter int HAS_LOCK         = 1,
    parameter int SMALL_INFO_SEGS  = 1,
    parameter int MAIN_SEGS        = `FES_MAIN_SEGS,
    parameter int ERASE_FTG_CYCLES = `FES_ERASE_FTG_CYCLES
) (
    // clock and reset
    input  wire logic                        clk_sys_i,
    input  wire logic                        rst_i,
    // wishbone slave
    input  wire logic                        wb_cyc_i,
    input  wire logic                        wb_stb_i,
    input  wire logic                        wb_we_i,
    input  wire logic [7:0]                  wb_adr_i,
    input  wire logic [3:0]                  wb_sel_i,
    input  wire logic [31:0]                 wb_dat_i,
    output logic      [31:0]                 wb_dat_o,
    output logic                             wb_ack_o,
    // timing generator clock sources, from other domains
    input  wire logic                        aux_clock_i,
    input  wire logic                        sub_main_clock_i,
    // cpu flash accesses
    input  wire logic                        fa_req_i,
    input  wire logic                        fa_we_i,
    input  wire logic                        fa_from_flash_i,
    input  wire flash_erase_pkg::flash_addr_t fa_addr_i,
    input  wire logic [15:0]                 fa_wdata_i,
    output logic                             cpu_stall_o,
    // flash array side
    output logic                             busy_o,
    output logic                             timing_gen_on_o,
    output logic                             voltage_gen_on_o,
    output logic                             ftg_tick_o,
    output logic      [1:0]                  erase_main_o,
    output logic      [1:0]                  erase_info_o,
    output logic                             erase_seg_o,
    output logic                             erase_seg_array_o,
    output flash_erase_pkg::flash_addr_t     erase_seg_base_o,
    output logic                             arr_prog_o,
    output flash_erase_pkg::flash_addr_t     arr_prog_addr_o,
    output logic      [15:0]                 arr_prog_data_o
);
    import flash_erase_pkg::*;

    localparam int INFO_SEG_BYTES = SMALL_INFO_SEGS != 0 ?
                                    `FES_INFO_SEG_SMALL : `FES_INFO_SEG_LARGE;
    localparam int INFO_SEGS      = SMALL_INFO_SEGS != 0 ? 4 : 2;
    localparam int INFO_BYTES     = INFO_SEGS * INFO_SEG_BYTES;
    localparam int MAIN_BYTES     = MAIN_SEGS * `FES_MAIN_SEG_BYTES;
    localparam logic [16:0] INFO_LO  = {1'b0, `FES_INFO_BASE};
    localparam logic [16:0] INFO_HI  = INFO_LO + 17'(INFO_BYTES);
    localparam logic [16:0] SEGA_HI  = INFO_LO + 17'(INFO_SEG_BYTES);
    localparam logic [16:0] MAIN_LO  = {1'b0, `FES_MAIN_BASE};
    localparam logic [16:0] MAIN_HI  = MAIN_LO + 17'(MAIN_BYTES);
    localparam logic [15:0] MAIN_MSK = ~16'(`FES_MAIN_SEG_BYTES - 1);
    localparam logic [15:0] INFO_MSK = ~16'(INFO_SEG_BYTES - 1);
    localparam logic [15:0] ERASE_LAST = 16'(ERASE_FTG_CYCLES - 1);

    // registers
    logic [5:0]          ctrl_ff;
    clk_src_e            clk_src_ff;
    logic [5:0]          clk_div_ff;
    logic                lock_ff;
    logic                accv_ff;
    logic                busy_ff;
    logic                stall_ff;
    seq_state_e          state_ff;
    logic                ack_ff;
    logic [31:0]         rdata_ff;
    logic [2:0]          aux_sync_ff;
    logic [2:0]          sub_sync_ff;
    logic [5:0]          div_cnt_ff;
    logic                ftg_ff;
    logic [15:0]         erase_cnt_ff;
    logic [1:0]          erase_main_ff;
    logic [1:0]          erase_info_ff;
    logic                erase_seg_ff;
    logic                erase_arr_ff;
    flash_addr_t         seg_base_ff;
    logic                prog_ff;
    flash_addr_t         prog_addr_ff;
    logic [15:0]         prog_data_ff;

    // decode
    logic                wb_req;
    logic                wr_ctrl;
    logic                wr_clk;
    logic                wr_stat;
    logic                lock_eff;
    logic                global_eff;
    logic [1:0]          arr_onehot;
    erase_mode_e         mode;
    logic [16:0]         addr_x;
    logic                in_main;
    logic                in_info;
    logic                in_sega;
    logic                hit;
    logic                trigger;
    logic                prog_req;
    logic                src_tick;
    logic                erase_done;

    assign wb_req  = wb_cyc_i && wb_stb_i && !ack_ff;
    assign wr_ctrl = wb_req && wb_we_i && wb_adr_i == `FES_OFS_CTRL && wb_sel_i[0];
    assign wr_clk  = wb_req && wb_we_i && wb_adr_i == `FES_OFS_CLKCFG;
    assign wr_stat = wb_req && wb_we_i && wb_adr_i == `FES_OFS_STATUS && wb_sel_i[0];

    assign lock_eff   = HAS_LOCK != 0 && lock_ff;
    assign global_eff = DUAL_ARRAY != 0 && ctrl_ff[`FES_CTRL_GLOBAL]
                        && ctrl_ff[`FES_CTRL_MASS];
    assign arr_onehot = (DUAL_ARRAY != 0 && ctrl_ff[`FES_CTRL_ARRAY]) ? 2'h2 : 2'h1;
    assign mode       = erase_mode_e'({ctrl_ff[`FES_CTRL_MASS],
                                       ctrl_ff[`FES_CTRL_ERASE]});

    assign addr_x  = {1'b0, fa_addr_i};
    assign in_main = addr_x >= MAIN_LO && addr_x < MAIN_HI;
    assign in_info = addr_x >= INFO_LO && addr_x < INFO_HI;
    assign in_sega = in_info && addr_x < SEGA_HI;

    // range test of the dummy write for each erase mode
    always_comb begin
        unique case (mode)
            MODE_SEGMENT: hit = in_main || (in_info && !(in_sega && lock_eff));
            MODE_MASS:    hit = in_main;
            MODE_ALL:     hit = in_main || in_info;
            MODE_NONE:    hit = 1'b0;
        endcase
    end

    // misses fall through silently, no flag and no array change
    assign trigger  = fa_req_i && fa_we_i && !busy_ff && hit;
    assign prog_req = fa_req_i && fa_we_i && !busy_ff && mode == MODE_NONE
                      && ctrl_ff[`FES_CTRL_PROG] && (in_main || in_info)
                      && !(in_sega && lock_eff);

    // wishbone handshake, one wait state
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= wb_req;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            rdata_ff <= 32'h0;
        end else if (wb_req && !wb_we_i) begin
            unique case (wb_adr_i)
                `FES_OFS_CTRL:   rdata_ff <= {26'h0, ctrl_ff};
                `FES_OFS_CLKCFG: rdata_ff <= {18'h0, clk_div_ff, 6'h0, clk_src_ff};
                `FES_OFS_STATUS: rdata_ff <= {29'h0, accv_ff, lock_eff, busy_ff};
                default:         rdata_ff <= 32'h0;
            endcase
        end
    end

    // control selects; software changes are ignored while an erase runs
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            ctrl_ff <= `FES_CTRL_RST;
        end else if (erase_done) begin
            ctrl_ff[`FES_CTRL_ERASE]  <= 1'b0;
            ctrl_ff[`FES_CTRL_MASS]   <= 1'b0;
            ctrl_ff[`FES_CTRL_GLOBAL] <= 1'b0;
        end else if (wr_ctrl && !busy_ff) begin
            ctrl_ff <= wb_dat_i[5:0];
            if (DUAL_ARRAY == 0) begin
                ctrl_ff[`FES_CTRL_GLOBAL] <= 1'b0;
                ctrl_ff[`FES_CTRL_ARRAY]  <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            clk_src_ff <= clk_src_e'(`FES_CLK_SRC_RST);
            clk_div_ff <= `FES_CLK_DIV_RST;
        end else if (wr_clk && !busy_ff) begin
            if (wb_sel_i[0]) begin
                clk_src_ff <= clk_src_e'(wb_dat_i[`FES_CLK_SRC_LSB +: 2]);
            end
            if (wb_sel_i[1]) begin
                clk_div_ff <= wb_dat_i[`FES_CLK_DIV_LSB +: 6];
            end
        end
    end

    // lock toggles on a written 1
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            lock_ff <= `FES_LOCK_RST;
        end else if (wr_stat && wb_dat_i[`FES_STAT_LOCK]) begin
            lock_ff <= !lock_ff;
        end
    end

    // access violation: write 1 clears, a new violation wins
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            accv_ff <= 1'b0;
        end else if (fa_req_i && busy_ff) begin
            accv_ff <= 1'b1;
        end else if (wr_stat && wb_dat_i[`FES_STAT_ACCV]) begin
            accv_ff <= 1'b0;
        end
    end

    // clock sources from other domains: two stages, third only for the edge
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            aux_sync_ff <= 3'h0;
            sub_sync_ff <= 3'h0;
        end else begin
            aux_sync_ff <= {aux_sync_ff[1:0], aux_clock_i};
            sub_sync_ff <= {sub_sync_ff[1:0], sub_main_clock_i};
        end
    end

    // main clock is the system clock itself, so every cycle is a tick
    always_comb begin
        unique case (clk_src_ff)
            SRC_AUX:      src_tick = aux_sync_ff[1] && !aux_sync_ff[2];
            SRC_SUB_MAIN: src_tick = sub_sync_ff[1] && !sub_sync_ff[2];
            default:      src_tick = 1'b1;
        endcase
    end

    // divider runs only while erasing, generator is off in read mode
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            div_cnt_ff <= 6'h0;
            ftg_ff     <= 1'b0;
        end else if (!busy_ff || erase_done) begin
            // stop at erase end so no tick leaks into read mode
            div_cnt_ff <= 6'h0;
            ftg_ff     <= 1'b0;
        end else if (src_tick && div_cnt_ff == clk_div_ff) begin
            div_cnt_ff <= 6'h0;
            ftg_ff     <= 1'b1;
        end else begin
            div_cnt_ff <= div_cnt_ff + (src_tick ? 6'h1 : 6'h0);
            ftg_ff     <= 1'b0;
        end
    end

    // fixed length in generator ticks, whatever the array size
    assign erase_done = state_ff == ST_ERASE && ftg_ff && erase_cnt_ff == ERASE_LAST;

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            erase_cnt_ff <= 16'h0;
        end else if (state_ff == ST_READ || erase_done) begin
            erase_cnt_ff <= 16'h0;
        end else if (ftg_ff) begin
            erase_cnt_ff <= erase_cnt_ff + 16'h1;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            state_ff <= ST_READ;
            busy_ff  <= 1'b0;
            stall_ff <= 1'b0;
        end else begin
            unique case (state_ff)
                ST_READ: begin
                    if (trigger) begin
                        state_ff <= ST_ERASE;
                        busy_ff  <= 1'b1;
                        stall_ff <= fa_from_flash_i;
                    end
                end
                ST_ERASE: begin
                    if (erase_done) begin
                        state_ff <= ST_READ;
                        busy_ff  <= 1'b0;
                        stall_ff <= 1'b0;
                    end
                end
            endcase
        end
    end

    // erase targets held for the whole cycle; an erased array reads all ones
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            erase_main_ff <= 2'h0;
            erase_info_ff <= 2'h0;
            erase_seg_ff  <= 1'b0;
            erase_arr_ff  <= 1'b0;
            seg_base_ff   <= 16'h0;
        end else if (erase_done) begin
            erase_main_ff <= 2'h0;
            erase_info_ff <= 2'h0;
            erase_seg_ff  <= 1'b0;
        end else if (trigger) begin
            erase_arr_ff <= arr_onehot[1];
            if (mode == MODE_SEGMENT) begin
                erase_seg_ff <= 1'b1;
                seg_base_ff  <= fa_addr_i & (in_main ? MAIN_MSK : INFO_MSK);
            end else begin
                erase_main_ff <= global_eff ? 2'h3 : arr_onehot;
                if (mode == MODE_ALL && !lock_eff) begin
                    erase_info_ff <= global_eff ? 2'h3 : arr_onehot;
                end
            end
        end
    end

    // program pass-through; the array only clears bits, never sets them
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            prog_ff      <= 1'b0;
            prog_addr_ff <= 16'h0;
            prog_data_ff <= 16'hffff;
        end else begin
            prog_ff <= prog_req;
            if (prog_req) begin
                prog_addr_ff <= fa_addr_i;
                prog_data_ff <= fa_wdata_i;
            end
        end
    end

    assign wb_dat_o          = rdata_ff;
    assign wb_ack_o          = ack_ff;
    assign cpu_stall_o       = stall_ff;
    assign busy_o            = busy_ff;
    assign timing_gen_on_o   = busy_ff;
    assign voltage_gen_on_o  = busy_ff;
    assign ftg_tick_o        = ftg_ff;
    assign erase_main_o      = erase_main_ff;
    assign erase_info_o      = erase_info_ff;
    assign erase_seg_o       = erase_seg_ff;
    assign erase_seg_array_o = erase_arr_ff;
    assign erase_seg_base_o  = seg_base_ff;
    assign arr_prog_o        = prog_ff;
    assign arr_prog_addr_o   = prog_addr_ff;
    assign arr_prog_data_o   = prog_data_ff;

    // checks
    sequence s_trig;
        trigger;
    endsequence

    sequence s_erase_run;
        state_ff == ST_ERASE && !erase_done;
    endsequence

    property p_busy_after_trig;
        @(posedge clk_sys_i) disable iff (rst_i) s_trig |=> busy_ff && timing_gen_on_o;
    endproperty
    a_busy_after_trig: assert property (p_busy_after_trig)
        else $error("busy did not rise after dummy write");

    property p_done_clears;
        @(posedge clk_sys_i) disable iff (rst_i)
            erase_done |=> !busy_ff && !ctrl_ff[`FES_CTRL_ERASE] && !ctrl_ff[`FES_CTRL_MASS]
                           && !ctrl_ff[`FES_CTRL_GLOBAL] && !cpu_stall_o;
    endproperty
    a_done_clears: assert property (p_done_clears)
        else $error("erase end did not clear busy and selects");

    property p_miss_quiet;
        @(posedge clk_sys_i) disable iff (rst_i)
            fa_req_i && fa_we_i && !busy_ff && !hit |=> !busy_ff && $stable(accv_ff);
    endproperty
    a_miss_quiet: assert property (p_miss_quiet)
        else $error("out of range dummy write had an effect");

    property p_lock_toggle;
        @(posedge clk_sys_i) disable iff (rst_i)
            wr_stat && wb_dat_i[`FES_STAT_LOCK] |=> lock_ff != $past(lock_ff);
    endproperty
    a_lock_toggle: assert property (p_lock_toggle)
        else $error("lock did not toggle on written one");

    property p_accv_set;
        @(posedge clk_sys_i) disable iff (rst_i) fa_req_i && busy_ff |=> accv_ff;
    endproperty
    a_accv_set: assert property (p_accv_set)
        else $error("access while busy not flagged");

    property p_ram_no_stall;
        @(posedge clk_sys_i) disable iff (rst_i)
            trigger && !fa_from_flash_i |=> !cpu_stall_o [*3];
    endproperty
    a_ram_no_stall: assert property (p_ram_no_stall)
        else $error("cpu stalled for ram triggered erase");

    property p_flash_stall;
        @(posedge clk_sys_i) disable iff (rst_i)
            trigger && fa_from_flash_i |=> cpu_stall_o && busy_ff;
    endproperty
    a_flash_stall: assert property (p_flash_stall)
        else $error("cpu not stalled for flash triggered erase");

    property p_locked_info;
        @(posedge clk_sys_i) disable iff (rst_i)
            trigger && lock_eff |=> erase_info_o == 2'h0
                                    && !(erase_seg_o && erase_seg_base_o == INFO_LO[15:0]);
    endproperty
    a_locked_info: assert property (p_locked_info)
        else $error("locked info memory was targeted");

    property p_read_mode;
        @(posedge clk_sys_i) disable iff (rst_i)
            !busy_ff |-> !ftg_tick_o && !voltage_gen_on_o && erase_cnt_ff == 16'h0;
    endproperty
    a_read_mode: assert property (p_read_mode)
        else $error("generators active in read mode");

    property p_busy_whole;
        @(posedge clk_sys_i) disable iff (rst_i) s_erase_run |=> busy_ff && timing_gen_on_o;
    endproperty
    a_busy_whole: assert property (p_busy_whole)
        else $error("busy dropped before erase end");
endmodule

// File: test/cpu_flash_model.sv
// cpu side model: issues flash accesses, holds off while stalled
`timescale 1ns/100ps
module cpu_flash_model (
    // clock
    input  wire logic        clk_sys_i,
    // requests from the bench
    input  wire logic        go_i,
    input  wire logic        we_i,
    input  wire logic        from_flash_i,
    input  wire logic [15:0] addr_i,
    // design side
    input  wire logic        cpu_stall_i,
    output logic             fa_req_o,
    output logic             fa_we_o,
    output logic             fa_from_flash_o,
    output logic      [15:0] fa_addr_o,
    output logic      [15:0] fa_wdata_o
);
    // a held cpu cannot fetch, so it issues nothing
    always_ff @(posedge clk_sys_i) begin
        fa_req_o        <= go_i && !cpu_stall_i;
        fa_we_o         <= we_i;
        fa_from_flash_o <= from_flash_i;
        // released lines toggle so stale values never pass
        fa_addr_o       <= go_i ? addr_i : ~fa_addr_o;
        fa_wdata_o      <= go_i ? ~addr_i : ~fa_wdata_o;
    end
endmodule

// File: test/testbench.sv
// self-checking bench for the flash erase sequencer
`timescale 1ns/100ps
module testbench;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        aux = 1'b0;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        wwe = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [31:0] wdat = 32'h0;
    logic        go = 1'b0;
    logic        gwe = 1'b0;
    logic        gff = 1'b0;
    logic [15:0] gadr = 16'h0;
    logic [31:0] rdat, q;
    logic        ack, stall, busy, tgen, vgen, tick, eseg, req, fwe, fff, earr, prog;
    logic [1:0]  emain, einfo;
    logic [15:0] base, fadr, fdat, padr, pdat;
    int          fails = 0;
    int          n_checks = 0;
    int          tk, c0, c1;

    always #2.5 clk = ~clk;
    always #41 aux = ~aux;

    flash_erase_sequencer #(.ERASE_FTG_CYCLES(4)) i_dut (
        .clk_sys_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(wwe), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .aux_clock_i(aux), .sub_main_clock_i(~aux),
        .fa_req_i(req), .fa_we_i(fwe), .fa_from_flash_i(fff), .fa_addr_i(fadr),
        .fa_wdata_i(fdat), .cpu_stall_o(stall), .busy_o(busy), .timing_gen_on_o(tgen),
        .voltage_gen_on_o(vgen), .ftg_tick_o(tick), .erase_main_o(emain),
        .erase_info_o(einfo), .erase_seg_o(eseg), .erase_seg_array_o(earr),
        .erase_seg_base_o(base), .arr_prog_o(prog), .arr_prog_addr_o(padr),
        .arr_prog_data_o(pdat)
    );

    cpu_flash_model i_cpu (
        .clk_sys_i(clk), .go_i(go), .we_i(gwe), .from_flash_i(gff), .addr_i(gadr),
        .cpu_stall_i(stall), .fa_req_o(req), .fa_we_o(fwe), .fa_from_flash_o(fff),
        .fa_addr_o(fadr), .fa_wdata_o(fdat)
    );

    task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %s exp %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic bus(logic w, logic [7:0] a, logic [31:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        wwe <= w;
        adr <= a;
        wdat <= d;
        do @(posedge clk); while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    task automatic rd(string nm, logic [7:0] a, logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(nm, q, e);
    endtask

    // one cpu access, returns once the design has taken it
    task automatic fa(logic [15:0] a, logic w, logic f);
        @(posedge clk);
        go <= 1'b1;
        gwe <= w;
        gff <= f;
        gadr <= a;
        @(posedge clk);
        go <= 1'b0;
        @(posedge clk);
        #1;
    endtask

    task automatic wait_done();
        tk = 0;
        c0 = 0;
        while (busy === 1'b1 && c0 < 500) begin
            @(posedge clk);
            #1;
            tk += int'(tick === 1'b1);
            c0++;
        end
        chk("busy_end", busy, 32'h0);
    endtask

    task automatic t_reset();
        chk("idle", {busy, tgen, vgen}, 32'h0);
        rd("ctrl", 8'h00, 32'h0);
        rd("clkcfg", 8'h04, 32'h1);
        rd("status", 8'h08, 32'h2);
        rd("unmapped", 8'h0c, 32'h0);
    endtask

    task automatic t_lock();
        bus(1'b1, 8'h08, 32'h0);
        rd("lock_w0", 8'h08, 32'h2);
        bus(1'b1, 8'h08, 32'h2);
        rd("lock_t1", 8'h08, 32'h0);
        bus(1'b1, 8'h08, 32'h2);
        rd("lock_t2", 8'h08, 32'h2);
    endtask

    task automatic t_seg(logic [31:0] cfg);
        bus(1'b1, 8'h04, cfg);
        bus(1'b1, 8'h00, 32'h1);
        fa(16'hf210, 1'b1, 1'b1);
        chk("start", {busy, stall, eseg, tgen, vgen, earr}, 32'h3e);
        chk("seg_main", emain, 32'h0);
        wait_done();
        chk("ticks", tk, 32'h4);
        chk("base", base, 32'hf200);
        chk("resume", stall, 32'h0);
        rd("ctrl_clr", 8'h00, 32'h0);
    endtask

    task automatic t_mode();
        for (int i = 0; i < 3; i++) begin
            // last pass unlocks so all-erase reaches info memory
            if (i == 2) bus(1'b1, 8'h08, 32'h2);
            bus(1'b1, 8'h00, (i == 0) ? 32'h2 : 32'h3);
            fa(16'hf400, 1'b1, 1'b0);
            chk("ram", {busy, stall}, 32'h2);
            chk("main", emain, 32'h1);
            chk("info", einfo, (i == 2) ? 32'h1 : 32'h0);
            wait_done();
        end
    endtask

    task automatic t_range();
        bus(1'b1, 8'h08, 32'h2);
        bus(1'b1, 8'h00, 32'h2);
        fa(16'h1080, 1'b1, 1'b0);
        chk("mass_info", busy, 32'h0);
        bus(1'b1, 8'h00, 32'h1);
        fa(16'h2000, 1'b1, 1'b0);
        chk("outside", busy, 32'h0);
        fa(16'h1000, 1'b1, 1'b0);
        chk("locked", busy, 32'h0);
        rd("noflag", 8'h08, 32'h2);
        bus(1'b1, 8'h08, 32'h2);
        fa(16'h1000, 1'b1, 1'b0);
        chk("unlocked", {busy, eseg, base}, {16'h3, 16'h1000});
        // read of flash while the erase runs
        fa(16'hf000, 1'b0, 1'b0);
        wait_done();
        rd("accv", 8'h08, 32'h4);
        bus(1'b1, 8'h08, 32'h4);
        rd("accv_clr", 8'h08, 32'h0);
    endtask

    task automatic t_prog();
        bus(1'b1, 8'h00, 32'h8);
        fa(16'hf100, 1'b1, 1'b0);
        chk("prog", {prog, padr}, 32'h1f100);
        chk("prog_data", pdat, 32'h0eff);
        chk("prog_idle", busy, 32'h0);
        bus(1'b1, 8'h08, 32'h2);
        fa(16'h1000, 1'b1, 1'b0);
        chk("prog_locked", prog, 32'h0);
    endtask

    task automatic finish_test();
        if (fails == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_lock();
        t_seg(32'h2);
        c1 = c0;
        t_seg(32'h102);
        chk("divider", c0 - c1, 32'h4);
        t_seg(32'h0);
        t_seg(32'h1);
        t_mode();
        t_range();
        t_prog();
        finish_test();
    end

    // the whole run needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clk);
        fails++;
        finish_test();
    end
endmodule
